// ---- bmc_top.sv ----
// Strap sensing, secondary clock gating, general-purpose pins and hot-swap control
// Notes on behaviour
// - Primary speed select high means 66, low 33
// - Secondary 66 only when wired-OR sense reads high
// - Primary select low: pull sense low in the reset hold
// - Strap high and D3hot: secondary clocks held 0
// - Strap low: D3hot leaves secondary clocks running
// - Four pins with enable, output and input registers
// - Hot-swap mode: pin 3 becomes ejector switch input
// - Ejector edge drives event output low
// - Status lamp follows software lamp bit
// - Mode 0 low, mode 1 high enables hot-swap
// - Mode 0 high disables hot-swap, pin 3 general
`timescale 1ns/1ps
module bmc_top
  import bmc_pkg::*;
#(
  parameter int NUM_SEC_CLK = 10,
  parameter int HOLD_CYC = BMC_HOLD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Board straps and speed pins
  input wire logic primary_speed_select,
  input wire logic secondary_speed_sense_i,
  output logic secondary_speed_sense_o,
  output logic secondary_speed_sense_oe,
  input wire logic bus_power_clock_ctl_strap,
  input wire logic mode_sel_0,
  input wire logic mode_sel_1,
  // Speed indications
  output logic primary_speed_66,
  output logic secondary_speed_66,
  // Secondary clock outputs
  output logic [NUM_SEC_CLK-1:0] sec_clk_o,
  // General-purpose pins, pin 3 doubles as the ejector switch input
  input wire logic [BMC_NUM_PINS-1:0] gpio_i,
  output logic [BMC_NUM_PINS-1:0] gpio_o,
  output logic [BMC_NUM_PINS-1:0] gpio_oe,
  // Hot-swap outputs
  output logic insert_extract_event_n,
  output logic swap_status_lamp
);

  // Phase of the reset hold that follows release of hresetn
  typedef enum logic [0:0] {
    BMC_PH_HOLD = 1'b0,
    BMC_PH_RUN = 1'b1
  } bmc_phase_t;

  // All state of the block except the bus answer flops in one record
  typedef struct packed {
    logic wr_pend;                     // Write data phase pending
    logic [7:0] wr_addr;               // Address captured in the address phase
    logic wr_hit;                      // Address lies inside the register window
    logic [31:0] rdata;                // Read data for the data phase
    logic [1:0] pm_state;              // Software power state
    logic [3:0] pin_oe_reg;            // Software pin output enables
    logic [3:0] pin_out_reg;           // Software pin output data
    logic [3:0] pin_oe;                // Enables actually driven at the pins
    logic [3:0] pin_out;               // Data actually driven at the pins
    logic lamp;                        // Status lamp bit
    logic evt_pend;                    // Sticky insertion or extraction event
    logic evt_n;                       // Active-low event pin
    logic sw_prev;                     // Previous filtered ejector level
    bmc_phase_t phase;                 // Reset hold or running
    logic [BMC_HOLD_W-1:0] hold_cnt;   // Cycles left in the reset hold
    logic sense_oe;                    // Pull-down enable on the sense line
    logic [NUM_SEC_CLK-1:0] sec_clk;   // Secondary clock levels
  } bmc_state_t;

  bmc_state_t s_q;
  bmc_state_t s_d;

  // Filtered pin inputs
  logic [8:0] raw_in;
  logic [8:0] sync_out;
  logic p66_s;
  logic s66_s;
  logic strap_s;
  logic ms0_s;
  logic ms1_s;
  logic [3:0] pins_s;

  // Combinational helpers
  logic hs_en;
  logic b2_act;
  logic eject_n;
  logic addr_take;

  // Hold length clipped to the counter width on purpose
  localparam logic [BMC_HOLD_W-1:0] HOLD_LAST = BMC_HOLD_W'(HOLD_CYC - 1);

  assign raw_in = {gpio_i, mode_sel_1, mode_sel_0, bus_power_clock_ctl_strap,
                   secondary_speed_sense_i, primary_speed_select};

  // Every strap and pin input crosses into hclk through the filter
  bmc_sync #(
    .W(9)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(raw_in),
    .dout(sync_out)
  );

  assign p66_s = sync_out[0];
  assign s66_s = sync_out[1];
  assign strap_s = sync_out[2];
  assign ms0_s = sync_out[3];
  assign ms1_s = sync_out[4];
  assign pins_s = sync_out[8:5];

  // Hot-swap only on the explicit code; every other strap pair leaves it off
  assign hs_en = !ms0_s && ms1_s;

  // B2 only when the strap allows it; strap low leaves clocks running in D3hot
  assign b2_act = strap_s && (s_q.pm_state == BMC_PM_D3HOT);

  // Ejector level is pin 3 as seen through the filter
  assign eject_n = pins_s[BMC_EJECT_PIN];

  // A transfer is taken when selected, ready and NONSEQ or SEQ
  assign addr_take = hsel && hready && htrans[1];

  // Next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;

    // Reset hold counts down, then the block runs
    if (s_q.phase == BMC_PH_HOLD)
    begin
      if (s_q.hold_cnt == '0)
      begin
        s_d.phase = BMC_PH_RUN;
      end
      else
      begin
        s_d.hold_cnt = s_q.hold_cnt - 1'b1;
      end
    end

    // Register writes land in the data phase
    if (s_q.wr_pend && s_q.wr_hit)
    begin
      unique case (s_q.wr_addr)
        BMC_OFS_CTRL:
        begin
          s_d.pm_state = hwdata[1:0];
        end
        BMC_OFS_PIN_OE:
        begin
          s_d.pin_oe_reg = hwdata[3:0];
        end
        BMC_OFS_PIN_OUT:
        begin
          s_d.pin_out_reg = hwdata[3:0];
        end
        BMC_OFS_SWAP_CSR:
        begin
          s_d.lamp = hwdata[BMC_CSR_LAMP_BIT];
          // Write one clears the event; a new event below still wins
          if (hwdata[BMC_CSR_EVT_BIT])
          begin
            s_d.evt_pend = 1'b0;
          end
        end
        default:
        begin
          // Read-only and unused offsets ignore writes
          s_d.pm_state = s_q.pm_state;
        end
      endcase
    end

    // Ejector edges count only in hot-swap mode and after the hold settles the filter
    s_d.sw_prev = eject_n;
    if (hs_en && (s_q.phase == BMC_PH_RUN) && (eject_n != s_q.sw_prev))
    begin
      s_d.evt_pend = 1'b1;
    end

    // Event pin mirrors the sticky bit, active low
    s_d.evt_n = !s_d.evt_pend;

    // Pin 3 is released from software control in hot-swap mode
    s_d.pin_out = s_d.pin_out_reg;
    s_d.pin_oe = s_d.pin_oe_reg;
    if (hs_en)
    begin
      s_d.pin_oe[BMC_EJECT_PIN] = 1'b0;
    end

    // Sense line pulled low through the hold when the primary runs at 33
    s_d.sense_oe = (s_d.phase == BMC_PH_HOLD) && !p66_s;

    // Secondary clocks toggle at half rate, parked low in B2
    if (b2_act)
    begin
      s_d.sec_clk = '0;
    end
    else
    begin
      s_d.sec_clk = ~s_q.sec_clk;
    end

    // Address phase: capture writes, prepare reads from post-write values
    s_d.wr_pend = addr_take && hwrite;
    s_d.wr_addr = haddr[7:0];
    s_d.wr_hit = (haddr[31:8] == 24'h000000);
    s_d.rdata = 32'h00000000;
    if (addr_take && !hwrite && (haddr[31:8] == 24'h000000))
    begin
      unique case (haddr[7:0])
        BMC_OFS_CTRL:
        begin
          s_d.rdata[1:0] = s_d.pm_state;
        end
        BMC_OFS_PIN_OE:
        begin
          s_d.rdata[3:0] = s_d.pin_oe_reg;
        end
        BMC_OFS_PIN_OUT:
        begin
          s_d.rdata[3:0] = s_d.pin_out_reg;
        end
        BMC_OFS_PIN_IN:
        begin
          s_d.rdata[3:0] = pins_s;
        end
        BMC_OFS_SWAP_CSR:
        begin
          s_d.rdata[BMC_CSR_EVT_BIT] = s_d.evt_pend;
          s_d.rdata[BMC_CSR_LAMP_BIT] = s_d.lamp;
          s_d.rdata[BMC_CSR_HSEN_BIT] = hs_en;
          s_d.rdata[BMC_CSR_SW_BIT] = eject_n;
        end
        BMC_OFS_STATUS:
        begin
          s_d.rdata[BMC_ST_P66_BIT] = p66_s;
          s_d.rdata[BMC_ST_S66_BIT] = s66_s;
          s_d.rdata[BMC_ST_STRAP_BIT] = strap_s;
          s_d.rdata[BMC_ST_B2_BIT] = b2_act;
          s_d.rdata[BMC_ST_HOLD_BIT] = (s_d.phase == BMC_PH_HOLD);
        end
        default:
        begin
          // Unmapped offsets read as zero with an OKAY answer
          s_d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // State register; control state comes up in the hold with pins released
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q.wr_pend <= 1'b0;
      s_q.wr_addr <= 8'h00;
      s_q.wr_hit <= 1'b0;
      s_q.rdata <= 32'h00000000;
      s_q.pm_state <= BMC_RST_PM;
      s_q.pin_oe_reg <= BMC_RST_PIN_OE;
      s_q.pin_out_reg <= BMC_RST_PIN_OUT;
      s_q.pin_oe <= BMC_RST_PIN_OE;
      s_q.pin_out <= BMC_RST_PIN_OUT;
      s_q.lamp <= BMC_RST_LAMP;
      s_q.evt_pend <= 1'b0;
      s_q.evt_n <= 1'b1;
      s_q.sw_prev <= 1'b0;
      s_q.phase <= BMC_PH_HOLD;
      s_q.hold_cnt <= HOLD_LAST;
      // Strap not yet seen while hresetn is low, so the line is not pulled here
      s_q.sense_oe <= 1'b0;
      s_q.sec_clk <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Bus answer: zero wait states, always OKAY; kept in flops for clean outputs
  logic hreadyout_q;
  logic hresp_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // Output wiring, each from a flip-flop except the sense output, which is tied low
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = s_q.rdata;
  assign primary_speed_66 = p66_s;
  assign secondary_speed_66 = s66_s;
  assign secondary_speed_sense_o = 1'b0 & s_q.sense_oe;
  assign secondary_speed_sense_oe = s_q.sense_oe;
  assign sec_clk_o = s_q.sec_clk;
  assign gpio_o = s_q.pin_out;
  assign gpio_oe = s_q.pin_oe;
  assign insert_extract_event_n = s_q.evt_n;
  assign swap_status_lamp = s_q.lamp;

endmodule

// ---- bmc_pkg.sv ----
// Shared constants for the bridge strap, clock-gating, general-purpose pin and hot-swap logic
package bmc_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] BMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] BMC_OFS_PIN_OE = 8'h04;
  localparam logic [7:0] BMC_OFS_PIN_OUT = 8'h08;
  localparam logic [7:0] BMC_OFS_PIN_IN = 8'h0C;
  localparam logic [7:0] BMC_OFS_SWAP_CSR = 8'h10;
  localparam logic [7:0] BMC_OFS_STATUS = 8'h14;

  // Field positions in the hot-swap control and status register
  localparam int BMC_CSR_EVT_BIT = 0;
  localparam int BMC_CSR_LAMP_BIT = 1;
  localparam int BMC_CSR_HSEN_BIT = 2;
  localparam int BMC_CSR_SW_BIT = 3;

  // Field positions in the status register
  localparam int BMC_ST_P66_BIT = 0;
  localparam int BMC_ST_S66_BIT = 1;
  localparam int BMC_ST_STRAP_BIT = 2;
  localparam int BMC_ST_B2_BIT = 3;
  localparam int BMC_ST_HOLD_BIT = 4;

  // Power state codes held in the control register
  localparam logic [1:0] BMC_PM_D0 = 2'h0;
  localparam logic [1:0] BMC_PM_D3HOT = 2'h3;

  // Values after reset
  localparam logic [1:0] BMC_RST_PM = 2'h0;
  localparam logic [3:0] BMC_RST_PIN_OE = 4'h0;
  localparam logic [3:0] BMC_RST_PIN_OUT = 4'h0;
  localparam logic BMC_RST_LAMP = 1'b0;

  // Number of general-purpose pins and the one shared with the ejector switch
  localparam int BMC_NUM_PINS = 4;
  localparam int BMC_EJECT_PIN = 3;

  // Reset hold time after release, in microseconds, and the clock rate
  localparam int BMC_HOLD_US = 100;
  localparam int BMC_CLK_MHZ = 125;
  localparam int BMC_HOLD_CYC = BMC_HOLD_US * BMC_CLK_MHZ;
  localparam int BMC_HOLD_W = 14;

endpackage

// ---- bmc_sync.sv ----
// Three-stage input synchroniser with a two-stage agreement filter per bit
`timescale 1ns/1ps
module bmc_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // One filter per bit, kept in a single generate loop
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;

    // First stage feeds only the second; the value moves on once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        out_q <= 1'b0;
      end
      else
      begin
        s1_q <= din[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
        begin
          out_q <= s3_q;
        end
      end
    end

    assign dout[i] = out_q;
  end

endmodule

// ---- bmc_top_assertions.sv ----
// Port-level checks for the strap, clock gate, pin and hot-swap block
`timescale 1ns/1ps
module bmc_checker
  import bmc_pkg::*;
#(
  parameter int NUM_SEC_CLK = 10,
  parameter int HOLD_CYC = BMC_HOLD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic primary_speed_select,
  input wire logic secondary_speed_sense_i,
  input wire logic secondary_speed_sense_oe,
  input wire logic bus_power_clock_ctl_strap,
  input wire logic mode_sel_0,
  input wire logic mode_sel_1,
  input wire logic primary_speed_66,
  input wire logic secondary_speed_66,
  input wire logic [NUM_SEC_CLK-1:0] sec_clk_o,
  input wire logic [BMC_NUM_PINS-1:0] gpio_oe,
  input wire logic insert_extract_event_n,
  input wire logic swap_status_lamp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_dp_q; // Data phase of a write to the hot-swap register
  // Track the write data phase so the clear bit can be seen with its data
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_dp_q <= 1'b0;
    else
      wr_dp_q <= hsel && hready && htrans[1] && hwrite && haddr == {24'h0, BMC_OFS_SWAP_CSR};
  // Address phase of a hot-swap register write
  sequence s_csr_wr;
    hsel && hready && htrans[1] && hwrite && haddr == {24'h0, BMC_OFS_SWAP_CSR};
  endsequence
  // Straps held long enough for the input filter to settle
  sequence s_hs_mode;
    (!mode_sel_0 && mode_sel_1) [*8];
  endsequence
  sequence s_no_hs;
    (mode_sel_0 || !mode_sel_1) [*8];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_p66_follow: assert property ($stable(primary_speed_select) [*8] |-> primary_speed_66 == primary_speed_select)
    else $error("primary speed does not follow its pin");
  a_s66_follow: assert property ($stable(secondary_speed_sense_i) [*8] |-> secondary_speed_66 == secondary_speed_sense_i)
    else $error("secondary speed does not follow sense line");
  a_sense_free: assert property (primary_speed_select [*8] |-> !secondary_speed_sense_oe)
    else $error("sense line pulled with primary select high");
  a_clk_held_zero: assert property ($stable(sec_clk_o) |-> sec_clk_o == '0)
    else $error("stopped secondary clocks not at zero");
  a_clk_runs: assert property (!bus_power_clock_ctl_strap [*8] |-> sec_clk_o != $past(sec_clk_o))
    else $error("secondary clocks stopped with strap low");
  a_lamp_follow: assert property (s_csr_wr ##1 1'b1 |=> swap_status_lamp == $past(hwdata[BMC_CSR_LAMP_BIT]))
    else $error("lamp does not follow written bit");
  a_event_holds: assert property (!insert_extract_event_n && !(wr_dp_q && hwdata[BMC_CSR_EVT_BIT]) |=> !insert_extract_event_n)
    else $error("event released without a clear");
  a_event_off: assert property (s_no_hs |-> !$fell(insert_extract_event_n))
    else $error("event raised with hot-swap disabled");
  a_pin3_switch: assert property (s_hs_mode |-> !gpio_oe[BMC_EJECT_PIN])
    else $error("pin 3 driven in hot-swap mode");
endmodule
bind bmc_top bmc_checker #(.NUM_SEC_CLK(NUM_SEC_CLK), .HOLD_CYC(HOLD_CYC)) i_bmc_checker (.*);

// ---- bmc_board.sv ----
// Board-side model: ejector switch, pin drivers, secondary agents and status lamp
`timescale 1ns/1ps
module bmc_board
  import bmc_pkg::*;
(
  input wire logic switch_open, // Ejector switch, open reads high through its pull-up
  input wire logic agents_66, // Every secondary agent releases its speed enable
  input wire logic [2:0] pin_drv, // Levels board parts put on pins 0 to 2
  input wire logic secondary_speed_sense_o,
  input wire logic secondary_speed_sense_oe,
  input wire logic [BMC_NUM_PINS-1:0] gpio_o,
  input wire logic [BMC_NUM_PINS-1:0] gpio_oe,
  input wire logic swap_status_lamp,
  output logic secondary_speed_sense_i,
  output logic [BMC_NUM_PINS-1:0] gpio_i,
  output logic lamp_lit
);
  // Pulled-up wired line: any agent or the bridge pulling low wins
  assign secondary_speed_sense_i = agents_66 && !(secondary_speed_sense_oe && !secondary_speed_sense_o);
  // Enabled bridge driver wins, else the board part or the switch
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & {switch_open, pin_drv});
  // Lamp lights while its drive is high
  assign lamp_lit = swap_status_lamp;
endmodule

// ---- tb.sv ----
// Self-checking bench for the strap, clock gate, pin and hot-swap block
`timescale 1ns/1ps
module tb;
  import bmc_pkg::*;
  typedef struct {string what; logic [31:0] exp; logic [31:0] msk;} bmc_note_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, probe, rd_dp, hs;
  logic [31:0] haddr, hwdata, hrdata, obs, seen, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize, pin_drv;
  logic [3:0] gpio_i, gpio_o, gpio_oe, exp4;
  logic [9:0] sec_clk_o;
  logic primary_speed_select, secondary_speed_sense_i, secondary_speed_sense_o;
  logic secondary_speed_sense_oe, bus_power_clock_ctl_strap, mode_sel_0, mode_sel_1;
  logic primary_speed_66, secondary_speed_66, insert_extract_event_n, swap_status_lamp;
  logic switch_open, agents_66, lamp_lit;
  int fail_count, tests_run, cyc;
  bmc_note_t notes[$]; // Expected results, oldest first
  bmc_note_t n;
  assign hready = hreadyout; // Single slave
  // Port snapshot compared by probes
  // Bit 23 is the lamp as the board sees it, so the far side of the lamp is checked too
  assign obs = {8'h0, lamp_lit, sec_clk_o, gpio_oe, gpio_o, insert_extract_event_n,
                swap_status_lamp, secondary_speed_sense_oe, primary_speed_66, secondary_speed_66};
  // Short hold so the run stays brief
  bmc_top #(.HOLD_CYC(20)) i_bmc_top (.*);
  bmc_board i_bmc_board (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One single-word bus transfer; a read leaves its expectation in the queue
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input string w);
  begin
    if (!wr)
      notes.push_back('{w, d, m});
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
  end
  endtask
  // Ask the watcher to compare the port snapshot at the next edge
  task automatic chk(input logic [31:0] d, input logic [31:0] m, input string w);
  begin
    notes.push_back('{w, d, m});
    probe <= 1'b1;
    @(posedge hclk);
    probe <= 1'b0;
  end
  endtask
  task automatic test_done;
  begin
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Watcher: takes the oldest note when read data or a probe appears
  always @(posedge hclk)
  begin
    if ((rd_dp && hreadyout) || probe)
    begin
      n = notes.pop_front();
      seen = probe ? obs : hrdata;
      tests_run++;
      if ((seen & n.msk) !== (n.exp & n.msk))
      begin
        fail_count++;
        $display("CHECK FAILED %s expected %h seen %h", n.what, n.exp & n.msk, seen & n.msk);
      end
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hready;
  end
  // Hang guard, far beyond the expected run
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hsel, hwrite, probe, rd_dp, bus_power_clock_ctl_strap, mode_sel_1} = 7'h0;
    {haddr, hwdata, htrans, pin_drv, primary_speed_select} = 70'h0;
    {mode_sel_0, switch_open, agents_66} = 3'h7;
    hsize = 3'h2;
    rnd = 32'hE177;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Inside the hold window the sense line is pulled low
    repeat (13) @(posedge hclk);
    chk(32'h14, 32'h1FFF, "hold window pins");
    repeat (30) @(posedge hclk);
    chk(32'h11, 32'h17, "sense released");
    xfer(1'b0, 8'h18, 32'h0, 32'hFFFFFFFF, "unmapped read");
    for (int i = 1; i >= 0; i--)
    begin
      primary_speed_select <= i[0];
      repeat (8) @(posedge hclk);
      xfer(1'b0, BMC_OFS_STATUS, {30'h0, 1'b1, i[0]}, 32'h3, "speed status");
      chk({30'h0, i[0], 1'b0}, 32'h2, "primary speed");
    end
    // Strap low first: D3hot must leave the clocks running
    for (int j = 0; j < 2; j++)
    begin
      bus_power_clock_ctl_strap <= j[0];
      xfer(1'b1, BMC_OFS_CTRL, {30'h0, BMC_PM_D3HOT}, 32'h0, "");
      repeat (10) @(posedge hclk);
      xfer(1'b0, BMC_OFS_STATUS, {28'h0, j[0], j[0], 2'h0}, 32'hC, "stop state");
      if (j == 1)
        chk(32'h0, 32'h7FE000, "secondary clocks");
    end
    xfer(1'b1, BMC_OFS_CTRL, 32'h0, 32'h0, "");
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      pin_drv <= rnd[10:8];
      switch_open <= rnd[11];
      xfer(1'b1, BMC_OFS_PIN_OE, {28'h0, rnd[3:0]}, 32'h0, "");
      xfer(1'b1, BMC_OFS_PIN_OUT, {28'h0, rnd[7:4]}, 32'h0, "");
      repeat (6) @(posedge hclk);
      exp4 = (rnd[3:0] & rnd[7:4]) | (~rnd[3:0] & rnd[11:8]);
      xfer(1'b0, BMC_OFS_PIN_IN, {28'h0, exp4}, 32'hF, "pin inputs");
      xfer(1'b0, BMC_OFS_PIN_OE, {28'h0, rnd[3:0]}, 32'hF, "pin enables");
      chk({19'h0, rnd[3:0], rnd[7:4], 5'h0}, 32'h1FE0, "pin drive");
    end
    // Every mode code; only the enabling one lets the switch raise an event
    xfer(1'b1, BMC_OFS_PIN_OE, 32'hF, 32'h0, "");
    for (int m = 0; m < 4; m++)
    begin
      hs = (m == 2);
      mode_sel_0 <= m[0];
      mode_sel_1 <= m[1];
      repeat (16) @(posedge hclk);
      xfer(1'b1, BMC_OFS_SWAP_CSR, {30'h0, m[0], 1'b1}, 32'h0, "");
      switch_open <= ~switch_open;
      repeat (10) @(posedge hclk);
      xfer(1'b0, BMC_OFS_SWAP_CSR, {29'h0, hs, m[0], hs}, 32'h7, "swap state");
      chk({8'h0, m[0], 10'h0, ~hs, 3'h7, 4'h0, ~hs, m[0], 3'h0}, 32'h801E18,
          "swap pins");
      xfer(1'b1, BMC_OFS_SWAP_CSR, {30'h0, m[0], 1'b1}, 32'h0, "");
      chk(32'h10, 32'h10, "event cleared");
    end
    // Second reset with the primary at 66: late in the hold the sense line must be free
    primary_speed_select <= 1'b1;
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // Still inside the hold here; the filter has long since seen the fast primary
    repeat (13) @(posedge hclk);
    chk(32'h13, 32'h1FFF, "hold with fast primary");
    repeat (4) @(posedge hclk);
    test_done();
  end
endmodule
